//--- hw/psm_regs.svh
`ifndef PSM_REGS_SVH
`define PSM_REGS_SVH

// Clock rate in MHz
`define PSM_CLK_MHZ 50

// Inactivity time before standby, in ms, and its cycle count
`define PSM_INACT_TIME_MS 100
`define PSM_INACT_CYCLES (`PSM_INACT_TIME_MS * 1000 * `PSM_CLK_MHZ)

// Wake-up counter period in standby, in ms, and its cycle count
`define PSM_WAKE_TIME_MS 500
`define PSM_WAKE_CYCLES (`PSM_WAKE_TIME_MS * 1000 * `PSM_CLK_MHZ)

// Positions in the synchronised pin vector
`define PSM_SYNC_W 12
`define PSM_IN_CE 0
`define PSM_IN_VBAT 1
`define PSM_IN_IOPAD 2
`define PSM_IN_OVERCUR 3
`define PSM_IN_OVERTEMP 4
`define PSM_IN_BATMON 5
`define PSM_IN_HIGHTEMP 6
`define PSM_IN_HOSTIF 7
`define PSM_IN_SWP 8
`define PSM_IN_LPCD 9
`define PSM_IN_GPIO 10
`define PSM_IN_RECEIVE_PROTOCOL_WAKE 11

// Transmitter supply configuration encoding
`define PSM_TX_SUPPLY_DIRECT 1'b0
`define PSM_TX_SUPPLY_LDO 1'b1

`endif

//--- hw/psm_pkg.sv
`default_nettype none

package psm_pkg;

    typedef enum logic [4:0] {
        ST_POWER_OFF = 5'h01,
        ST_MGMT_OFF = 5'h02,
        ST_HARD_PD = 5'h04,
        ST_STANDBY = 5'h08,
        ST_ACTIVE = 5'h10
    } psm_state_t;

    typedef enum logic [1:0] {
        CMD_NOP = 2'h0,
        CMD_ACTIVE = 2'h1,
        CMD_STANDBY = 2'h2,
        CMD_HARD_PD = 2'h3
    } psm_cmd_t;

endpackage

`default_nettype wire

//--- hw/psm_sync.sv
`timescale 1ns/100ps
`default_nettype none

module psm_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] d_out
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= d_in;
            s2_r <= s1_r;
        end
    end

    assign d_out = s2_r;

endmodule

`default_nettype wire

//--- hw/psm_timer.sv
`timescale 1ns/100ps
`default_nettype none

module psm_timer #(
    parameter int unsigned W = 32,
    parameter int unsigned COUNT = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Control
    input wire logic run,
    input wire logic clear,
    output logic expired
);

    localparam logic [W-1:0] LAST = W'(COUNT - 1);

    logic [W-1:0] cnt_r;

    // Holds at the last count until stopped or cleared
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
        end else if (!run || clear) begin
            cnt_r <= '0;
        end else if (cnt_r != LAST) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign expired = run && !clear && (cnt_r == LAST);

endmodule

`default_nettype wire

//--- hw/psm_top.sv
// Overview of operation
// RULE1 - Chip enable rising edge restarts the device into active, from any state.
// RULE2 - After battery loss and return, chip enable low-to-high restarts into active.
// RULE3 - Chip enable held low keeps the device off with every clock stopped.
// RULE4 - Loss of the I/O pad supply sends the device to the off state.
// RULE5 - Off state exits only on battery reset, enable rise or pad supply return.
// RULE6 - Pad supply loss, overcurrent or overtemperature change the power state.
// RULE7 - Host commands request power transitions which the device carries out.
// RULE8 - Host or battery monitor trip enters hard power down; oscillator stays on.
// RULE9 - Hard power down exits on battery reset or chip enable rising edge.
// RULE10 - A set inactivity time moves active to standby, holding I/O and wake clock.
// RULE11 - Standby wakes on host, single-wire, card detect, counter, pad, GPIO, protocol, cool; pad is not a wake source here.
// RULE12 - Active state runs all internal clocks and processes events.
// RULE13 - Regulator-fed transmitter gets power control, current measuring and overcurrent guard.
// RULE14 - Battery-fed transmitter has power control, measuring and overcurrent guard disabled.
// RULE15 - Host keeps the RF field off until the supply configuration matches the board.
// RULE16 - Supply configuration lives in nonvolatile memory, surviving supply loss and reset.
// RULE17 - Host side and logic work regardless of driver supply; config changes any time.
// RULE18 - Low enable or pad supply loss outranks every other wake or standby cause.
`timescale 1ns/100ps
`default_nettype none
`include "psm_regs.svh"

module psm_top #(
    parameter int unsigned INACT_CYCLES = `PSM_INACT_CYCLES,
    parameter int unsigned WAKE_CYCLES = `PSM_WAKE_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Supply and enable pins
    input wire logic chip_enable_input,
    input wire logic vbat_ok,
    input wire logic io_pad_supply_ok,
    // Protection events
    input wire logic tx_overcurrent,
    input wire logic over_temp,
    input wire logic batt_monitor_trip,
    input wire logic tx_high_temp,
    // Wake-up and activity sources
    input wire logic host_if_activity,
    input wire logic single_wire_protocol_link,
    input wire logic low_power_card_detect,
    input wire logic gpio_wake,
    input wire logic receive_protocol_wake,
    // Host power commands
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_code,
    output logic cmd_ready,
    // Transmitter supply configuration
    input wire logic nv_tx_supply_cfg,
    input wire logic cfg_wr_valid,
    input wire logic cfg_wr_data,
    output logic nv_cfg_wr,
    output logic nv_cfg_wdata,
    // Power state and domain controls
    output logic [4:0] power_state,
    output logic core_restart,
    output logic all_clocks_run,
    output logic low_freq_oscillator_en,
    output logic wake_counter_clk_en,
    output logic low_power_resources_en,
    output logic io_state_hold,
    output logic dynamic_power_control_en,
    output logic tx_current_meas_en,
    output logic overcurrent_prot_en
);

    function automatic psm_pkg::psm_state_t cmd_target(input logic [1:0] code,
                                                       input psm_pkg::psm_state_t cur);
        case (psm_pkg::psm_cmd_t'(code))
            psm_pkg::CMD_ACTIVE: cmd_target = psm_pkg::ST_ACTIVE;
            psm_pkg::CMD_STANDBY: cmd_target = psm_pkg::ST_STANDBY;
            psm_pkg::CMD_HARD_PD: cmd_target = psm_pkg::ST_HARD_PD;
            default: cmd_target = cur;
        endcase
    endfunction

    logic [`PSM_SYNC_W-1:0] pin_raw;
    logic [`PSM_SYNC_W-1:0] pin_s;
    logic ce_s;
    logic vbat_s;
    logic io_s;
    logic ht_s;
    logic ce_d_r;
    logic io_d_r;
    logic ht_d_r;
    logic ce_rise;
    logic io_restore;
    logic ht_clear;
    logic wake_any;
    logic activity;
    logic cmd_fire;
    logic inact_exp;
    logic wake_exp;
    logic forced_off;
    logic quiet;
    logic trip;
    logic restart_nxt;
    logic tx_regulator_r;
    logic cfg_loaded_r;
    psm_pkg::psm_state_t state_r;
    psm_pkg::psm_state_t state_nxt;

    assign pin_raw = {receive_protocol_wake, gpio_wake, low_power_card_detect,
                      single_wire_protocol_link, host_if_activity, tx_high_temp,
                      batt_monitor_trip, over_temp, tx_overcurrent, io_pad_supply_ok,
                      vbat_ok, chip_enable_input};

    psm_sync #(
        .W(`PSM_SYNC_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .d_in(pin_raw),
        .d_out(pin_s)
    );

    assign ce_s = pin_s[`PSM_IN_CE];
    assign vbat_s = pin_s[`PSM_IN_VBAT];
    assign io_s = pin_s[`PSM_IN_IOPAD];
    assign ht_s = pin_s[`PSM_IN_HIGHTEMP];

    // Edge detection on synchronised levels
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ce_d_r <= 1'b0;
            io_d_r <= 1'b0;
            ht_d_r <= 1'b0;
        end else begin
            ce_d_r <= ce_s;
            io_d_r <= io_s;
            ht_d_r <= ht_s;
        end
    end

    assign ce_rise = ce_s && !ce_d_r;
    assign io_restore = io_s && !io_d_r;
    assign ht_clear = !ht_s && ht_d_r;

    assign cmd_ready = (state_r == psm_pkg::ST_ACTIVE) || (state_r == psm_pkg::ST_STANDBY);
    assign cmd_fire = cmd_valid && cmd_ready;
    assign activity = pin_s[`PSM_IN_HOSTIF] || pin_s[`PSM_IN_SWP]
                      || pin_s[`PSM_IN_RECEIVE_PROTOCOL_WAKE] || cmd_fire;

    psm_timer #(
        .W(32),
        .COUNT(INACT_CYCLES)
    ) u_inact (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .run(state_r == psm_pkg::ST_ACTIVE),
        .clear(activity),
        .expired(inact_exp)
    );

    psm_timer #(
        .W(32),
        .COUNT(WAKE_CYCLES)
    ) u_wake (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .run(state_r == psm_pkg::ST_STANDBY),
        .clear(1'b0),
        .expired(wake_exp)
    );

    // Standby wake sources
    assign wake_any = pin_s[`PSM_IN_HOSTIF] || pin_s[`PSM_IN_SWP]
                      || pin_s[`PSM_IN_LPCD] || wake_exp || pin_s[`PSM_IN_GPIO]
                      || pin_s[`PSM_IN_RECEIVE_PROTOCOL_WAKE] || ht_clear; // [RULE11]

    assign forced_off = vbat_s && (!ce_s || !io_s); // [RULE18]
    assign quiet = vbat_s && ce_s && io_s && !ce_rise;
    assign trip = (pin_s[`PSM_IN_OVERCUR] && overcurrent_prot_en)
                  || pin_s[`PSM_IN_OVERTEMP] || pin_s[`PSM_IN_BATMON]; // [RULE6] [RULE8]

    always_comb begin
        state_nxt = state_r;
        restart_nxt = 1'b0;
        if (!vbat_s) begin
            state_nxt = psm_pkg::ST_POWER_OFF;
        end else if (forced_off) begin
            state_nxt = psm_pkg::ST_MGMT_OFF; // [RULE3] [RULE4] [RULE18]
        end else if (ce_rise) begin
            state_nxt = psm_pkg::ST_ACTIVE; // [RULE1] [RULE2] [RULE9]
            restart_nxt = 1'b1;
        end else begin
            case (state_r)
                psm_pkg::ST_POWER_OFF: begin
                    // Supply back with enable already high: wait for a fresh rise
                    state_nxt = psm_pkg::ST_MGMT_OFF; // [RULE2]
                end
                psm_pkg::ST_MGMT_OFF: begin
                    if (io_restore) begin
                        state_nxt = psm_pkg::ST_ACTIVE; // [RULE5]
                        restart_nxt = 1'b1;
                    end
                end
                psm_pkg::ST_HARD_PD: begin
                    state_nxt = psm_pkg::ST_HARD_PD; // [RULE9]
                end
                psm_pkg::ST_STANDBY: begin
                    if (wake_any) begin
                        state_nxt = psm_pkg::ST_ACTIVE; // [RULE11]
                    end else if (cmd_fire) begin
                        state_nxt = cmd_target(cmd_code, state_r); // [RULE7]
                    end
                end
                psm_pkg::ST_ACTIVE: begin
                    if (trip) begin
                        state_nxt = psm_pkg::ST_HARD_PD; // [RULE6] [RULE8]
                    end else if (cmd_fire) begin
                        state_nxt = cmd_target(cmd_code, state_r); // [RULE7]
                    end else if (inact_exp) begin
                        state_nxt = psm_pkg::ST_STANDBY; // [RULE10]
                    end
                end
                default: begin
                    state_nxt = psm_pkg::ST_POWER_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= psm_pkg::ST_POWER_OFF;
            core_restart <= 1'b0;
        end else begin
            state_r <= state_nxt;
            core_restart <= restart_nxt;
        end
    end

    // Domain controls follow the state they are entered with
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            all_clocks_run <= 1'b0;
            low_freq_oscillator_en <= 1'b0;
            wake_counter_clk_en <= 1'b0;
            low_power_resources_en <= 1'b0;
            io_state_hold <= 1'b0;
        end else begin
            all_clocks_run <= (state_nxt == psm_pkg::ST_ACTIVE); // [RULE12] [RULE3]
            low_freq_oscillator_en <= (state_nxt == psm_pkg::ST_HARD_PD)
                                      || (state_nxt == psm_pkg::ST_STANDBY); // [RULE8]
            low_power_resources_en <= (state_nxt == psm_pkg::ST_HARD_PD)
                                      || (state_nxt == psm_pkg::ST_STANDBY); // [RULE8]
            wake_counter_clk_en <= (state_nxt == psm_pkg::ST_STANDBY); // [RULE10]
            io_state_hold <= (state_nxt == psm_pkg::ST_STANDBY); // [RULE10]
        end
    end

    assign power_state = state_r;

    // Supply configuration: mirror of the nonvolatile copy, loaded after reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_regulator_r <= `PSM_TX_SUPPLY_DIRECT;
            cfg_loaded_r <= 1'b0;
            nv_cfg_wr <= 1'b0;
            nv_cfg_wdata <= 1'b0;
        end else begin
            cfg_loaded_r <= 1'b1;
            nv_cfg_wr <= cfg_wr_valid; // [RULE16]
            if (cfg_wr_valid) begin
                tx_regulator_r <= cfg_wr_data; // [RULE17]
                nv_cfg_wdata <= cfg_wr_data; // [RULE16]
            end else if (!cfg_loaded_r) begin
                tx_regulator_r <= nv_tx_supply_cfg; // [RULE16]
            end
        end
    end

    // Measurement and protection only with the regulator feeding the amplifier
    assign dynamic_power_control_en = (tx_regulator_r == `PSM_TX_SUPPLY_LDO)
                                      && (state_r == psm_pkg::ST_ACTIVE); // [RULE13] [RULE14]
    assign tx_current_meas_en = (tx_regulator_r == `PSM_TX_SUPPLY_LDO)
                                && (state_r == psm_pkg::ST_ACTIVE); // [RULE13] [RULE14]
    assign overcurrent_prot_en = (tx_regulator_r == `PSM_TX_SUPPLY_LDO)
                                 && (state_r == psm_pkg::ST_ACTIVE); // [RULE13] [RULE14]

    logic mgmt_exit_cause;
    logic hpd_exit_cause;
    assign mgmt_exit_cause = !vbat_s || ce_rise || io_restore || !io_s;
    assign hpd_exit_cause = !vbat_s || ce_rise || forced_off;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_left_off;
        (state_r == psm_pkg::ST_POWER_OFF) ##1 (state_r == psm_pkg::ST_ACTIVE);
    endsequence
    sequence s_left_mgmt_off;
        (state_r == psm_pkg::ST_MGMT_OFF) ##1 (state_r != psm_pkg::ST_MGMT_OFF);
    endsequence
    sequence s_left_hpd;
        (state_r == psm_pkg::ST_HARD_PD) ##1 (state_r != psm_pkg::ST_HARD_PD);
    endsequence
    property p_ce_rise;
        (ce_rise && vbat_s && io_s) |=> (state_r == psm_pkg::ST_ACTIVE) && core_restart;
    endproperty
    a_ce_rise: assert property (p_ce_rise) else $error("enable rise did not restart"); // [RULE1]
    property p_off_restart;
        s_left_off |-> $past(ce_rise);
    endproperty
    a_off_restart: assert property (p_off_restart) else $error("restart without enable rise"); // [RULE2]
    property p_ce_low;
        (vbat_s && !ce_s) |=> (state_r == psm_pkg::ST_MGMT_OFF) && !all_clocks_run;
    endproperty
    a_ce_low: assert property (p_ce_low) else $error("enable low did not stop device"); // [RULE3]
    property p_pad_loss;
        (vbat_s && !io_s) |=> (state_r == psm_pkg::ST_MGMT_OFF);
    endproperty
    a_pad_loss: assert property (p_pad_loss) else $error("pad supply loss ignored"); // [RULE4]
    property p_mgmt_exit;
        s_left_mgmt_off |-> $past(mgmt_exit_cause);
    endproperty
    a_mgmt_exit: assert property (p_mgmt_exit) else $error("off state left without cause"); // [RULE5]
    property p_trip;
        (quiet && state_r == psm_pkg::ST_ACTIVE && trip) |=> (state_r == psm_pkg::ST_HARD_PD)
            ##0 low_freq_oscillator_en;
    endproperty
    a_trip: assert property (p_trip) else $error("trip did not enter hard power down"); // [RULE6]
    property p_cmd;
        (quiet && state_r == psm_pkg::ST_ACTIVE && !trip && cmd_fire
            && cmd_code == psm_pkg::CMD_STANDBY) |=> (state_r == psm_pkg::ST_STANDBY);
    endproperty
    a_cmd: assert property (p_cmd) else $error("standby command not carried out"); // [RULE7]
    property p_hpd_exit;
        s_left_hpd |-> $past(hpd_exit_cause);
    endproperty
    a_hpd_exit: assert property (p_hpd_exit) else $error("hard power down left early"); // [RULE9]
    property p_inact;
        (quiet && state_r == psm_pkg::ST_ACTIVE && !trip && !cmd_fire && inact_exp)
            |=> (state_r == psm_pkg::ST_STANDBY) && io_state_hold && wake_counter_clk_en;
    endproperty
    a_inact: assert property (p_inact) else $error("inactivity did not enter standby"); // [RULE10]
    property p_wake;
        (quiet && state_r == psm_pkg::ST_STANDBY && wake_any) |=> (state_r == psm_pkg::ST_ACTIVE);
    endproperty
    a_wake: assert property (p_wake) else $error("standby wake source ignored"); // [RULE11]
    property p_clocks;
        all_clocks_run |-> (state_r == psm_pkg::ST_ACTIVE);
    endproperty
    a_clocks: assert property (p_clocks) else $error("clocks run outside active"); // [RULE12]
    property p_direct_supply;
        (tx_regulator_r == `PSM_TX_SUPPLY_DIRECT)
            |-> !(dynamic_power_control_en || tx_current_meas_en || overcurrent_prot_en);
    endproperty
    a_direct_supply: assert property (p_direct_supply) else $error("protection on direct supply"); // [RULE14]
    property p_cfg_wr;
        cfg_wr_valid |=> nv_cfg_wr && (tx_regulator_r == $past(cfg_wr_data))
            && (nv_cfg_wdata == $past(cfg_wr_data));
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("configuration write lost"); // [RULE16]
    property p_priority;
        (forced_off && (wake_any || inact_exp || cmd_fire)) |=> (state_r == psm_pkg::ST_MGMT_OFF);
    endproperty
    a_priority: assert property (p_priority) else $error("off cause lost priority"); // [RULE18]

endmodule

`default_nettype wire

//--- verif/psm_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module psm_host_model #(
    parameter logic NV_INIT = 1'b1
) (
    // Clock
    input wire logic ref_clk,
    // Enable pin and commands
    output var logic chip_enable_input,
    output var logic cmd_valid,
    output var logic [1:0] cmd_code,
    input wire logic cmd_ready,
    // Supply configuration store
    output var logic nv_tx_supply_cfg,
    output var logic cfg_wr_valid,
    output var logic cfg_wr_data,
    input wire logic nv_cfg_wr,
    input wire logic nv_cfg_wdata
);
    initial begin
        chip_enable_input = 1'b1;
        cmd_valid = 1'b0;
        cmd_code = 2'h0;
        cfg_wr_valid = 1'b0;
        cfg_wr_data = 1'b0;
        nv_tx_supply_cfg = NV_INIT;
    end

    // Store has no reset, so its contents survive resets and supply loss
    always @(posedge ref_clk) begin
        if (nv_cfg_wr === 1'b1) begin
            nv_tx_supply_cfg <= nv_cfg_wdata;
        end
    end

    task automatic set_enable(input logic v);
        @(posedge ref_clk);
        chip_enable_input <= v;
    endtask

    // Request held until the block shows ready or 16 checks have failed; code scrambled after release
    task automatic send_cmd(input logic [1:0] c, output bit ok);
        int i;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        for (i = 0; i < 16; i++) begin
            #1;
            if (cmd_ready === 1'b1) break;
            @(posedge ref_clk);
        end
        ok = (i < 16);
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        cmd_code <= ~c;
    endtask

    // Supply configuration write strobed for one cycle; data scrambled after release
    task automatic write_cfg(input logic d);
        @(posedge ref_clk);
        cfg_wr_valid <= 1'b1;
        cfg_wr_data <= d;
        @(posedge ref_clk);
        cfg_wr_valid <= 1'b0;
        cfg_wr_data <= ~d;
    endtask
endmodule

`default_nettype wire

//--- verif/psm_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module psm_top_tb_top;
    localparam int INACT = 20;
    localparam int WAKE = 50;
    logic ref_clk, resetn, vbat_ok, io_pad_supply_ok, tx_high_temp;
    logic [2:0] trip_v;
    logic [4:0] wake_v;
    logic chip_enable_input, cmd_valid, cmd_ready, nv_tx_supply_cfg;
    logic cfg_wr_valid, cfg_wr_data, nv_cfg_wr, nv_cfg_wdata;
    logic [1:0] cmd_code;
    logic [4:0] power_state;
    logic core_restart, all_clocks_run, low_freq_oscillator_en, wake_counter_clk_en;
    logic low_power_resources_en, io_state_hold, dynamic_power_control_en;
    logic tx_current_meas_en, overcurrent_prot_en;
    int err_total;
    int checks;
    logic cfg_exp;
    bit ok;

    psm_top #(.INACT_CYCLES(INACT), .WAKE_CYCLES(WAKE)) u_psm_top (
        .ref_clk, .resetn, .chip_enable_input, .vbat_ok, .io_pad_supply_ok,
        .tx_overcurrent(trip_v[0]), .over_temp(trip_v[1]), .batt_monitor_trip(trip_v[2]),
        .tx_high_temp, .host_if_activity(wake_v[0]), .single_wire_protocol_link(wake_v[1]),
        .low_power_card_detect(wake_v[2]), .gpio_wake(wake_v[3]),
        .receive_protocol_wake(wake_v[4]), .cmd_valid, .cmd_code, .cmd_ready,
        .nv_tx_supply_cfg, .cfg_wr_valid, .cfg_wr_data, .nv_cfg_wr, .nv_cfg_wdata,
        .power_state, .core_restart, .all_clocks_run, .low_freq_oscillator_en,
        .wake_counter_clk_en, .low_power_resources_en, .io_state_hold,
        .dynamic_power_control_en, .tx_current_meas_en, .overcurrent_prot_en
    );

    psm_host_model u_psm_host_model (
        .ref_clk, .chip_enable_input, .cmd_valid, .cmd_code, .cmd_ready,
        .nv_tx_supply_cfg, .cfg_wr_valid, .cfg_wr_data, .nv_cfg_wr, .nv_cfg_wdata
    );

    function automatic logic [8:0] exp_flags(input logic [4:0] st, input logic cfg);
        logic act;
        logic sb;
        logic hp;
        act = (st == psm_pkg::ST_ACTIVE);
        sb = (st == psm_pkg::ST_STANDBY);
        hp = (st == psm_pkg::ST_HARD_PD);
        return {act | sb, act, hp | sb, hp | sb, sb, sb, {3{cfg & act}}};
    endfunction

    function automatic logic [8:0] flags_now();
        return {cmd_ready, all_clocks_run, low_freq_oscillator_en, low_power_resources_en,
            wake_counter_clk_en, io_state_hold, dynamic_power_control_en,
            tx_current_meas_en, overcurrent_prot_en};
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask

    // Bounded wait for a state, then its domain enables are compared
    task automatic wait_state(input logic [4:0] st, input int bound);
        int n;
        for (n = 0; n < bound; n++) begin
            @(posedge ref_clk);
            #1;
            if (power_state === st) break;
        end
        if (n == bound) begin
            chk(power_state, st);
            final_report();
        end
        chk(flags_now(), exp_flags(st, cfg_exp));
    endtask

    task automatic cmd(input logic [1:0] c);
        u_psm_host_model.send_cmd(c, ok);
        chk(ok, 1'b1);
        if (!ok) begin
            final_report();
        end
    endtask

    task automatic cfg_write(input logic d);
        u_psm_host_model.write_cfg(d);
        cfg_exp = d;
        #1;
        chk({nv_cfg_wr, nv_cfg_wdata, flags_now()},
            {1'b1, d, exp_flags(psm_pkg::ST_ACTIVE, d)});
        @(posedge ref_clk);
        #1;
        chk({nv_cfg_wr, nv_tx_supply_cfg}, {1'b0, d});
    endtask

    task automatic restart();
        u_psm_host_model.set_enable(1'b0);
        wait_state(psm_pkg::ST_MGMT_OFF, 8);
        u_psm_host_model.set_enable(1'b1);
        wait_state(psm_pkg::ST_ACTIVE, 8);
        chk(core_restart, 1'b1);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        void'($urandom(32'h9D08));
        resetn = 1'b0;
        vbat_ok = 1'b1;
        io_pad_supply_ok = 1'b1;
        tx_high_temp = 1'b0;
        trip_v = 3'h0;
        wake_v = 5'h00;
        err_total = 0;
        checks = 0;
        cfg_exp = 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(power_state, psm_pkg::ST_POWER_OFF);
        resetn <= 1'b1;
        wait_state(psm_pkg::ST_ACTIVE, 10);
        wait_state(psm_pkg::ST_STANDBY, INACT + 10);
        wait_state(psm_pkg::ST_ACTIVE, WAKE + 10);
        cfg_write(1'b0);
        cfg_write(1'b1);
        // Every wake source except the counter, the last being the high-temperature flag clearing
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            tx_high_temp <= (i == 5);
            cmd(psm_pkg::CMD_STANDBY);
            wait_state(psm_pkg::ST_STANDBY, 4);
            repeat (1 + $urandom_range(4)) @(posedge ref_clk);
            if (i < 5) wake_v[i] <= 1'b1;
            else tx_high_temp <= 1'b0;
            wait_state(psm_pkg::ST_ACTIVE, 8);
            @(posedge ref_clk);
            wake_v <= 5'h00;
            repeat (3) @(posedge ref_clk);
        end
        // Wake by command from standby, then a no-operation code in active
        cmd(psm_pkg::CMD_STANDBY);
        wait_state(psm_pkg::ST_STANDBY, 4);
        cmd(psm_pkg::CMD_ACTIVE);
        wait_state(psm_pkg::ST_ACTIVE, 4);
        cmd(psm_pkg::CMD_NOP);
        wait_state(psm_pkg::ST_ACTIVE, 1);
        for (int t = 0; t < 3; t++) begin
            @(posedge ref_clk);
            trip_v <= 3'b001 << t;
            wait_state(psm_pkg::ST_HARD_PD, 8);
            @(posedge ref_clk);
            trip_v <= 3'b000;
            restart();
        end
        // Wake sources must be ignored in hard power down
        cmd(psm_pkg::CMD_HARD_PD);
        for (int k = 0; k < 10; k++) begin
            @(posedge ref_clk);
            wake_v <= 5'($urandom);
        end
        @(posedge ref_clk);
        wake_v <= 5'h00;
        wait_state(psm_pkg::ST_HARD_PD, 1);
        restart();
        cfg_write(1'b0);
        @(posedge ref_clk);
        trip_v <= 3'b001;
        repeat (5) @(posedge ref_clk);
        #1;
        chk(power_state, psm_pkg::ST_ACTIVE);
        @(posedge ref_clk);
        trip_v <= 3'b000;
        repeat (3) @(posedge ref_clk);
        cfg_write(1'b1);
        // Pad loss coinciding with a wake source
        cmd(psm_pkg::CMD_STANDBY);
        @(posedge ref_clk);
        io_pad_supply_ok <= 1'b0;
        wake_v <= 5'h08;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(power_state, psm_pkg::ST_MGMT_OFF);
        @(posedge ref_clk);
        wake_v <= 5'h00;
        io_pad_supply_ok <= 1'b1;
        wait_state(psm_pkg::ST_ACTIVE, 8);
        chk(core_restart, 1'b1);
        @(posedge ref_clk);
        vbat_ok <= 1'b0;
        wait_state(psm_pkg::ST_POWER_OFF, 8);
        @(posedge ref_clk);
        vbat_ok <= 1'b1;
        wait_state(psm_pkg::ST_MGMT_OFF, 8);
        repeat (5) @(posedge ref_clk);
        #1;
        chk(power_state, psm_pkg::ST_MGMT_OFF);
        restart();
        final_report();
    end
endmodule

`default_nettype wire
